// >>> logic/bcdudc_top.sv
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
// Summary of operation
// - Store low copies counter into output latches
// - Count up when direction high, else down
// - Counter preset: high loads, low floats port
// - Compare preset high loads compare from port
// - Compare preset low: display off, scan stopped
// - Display control: high blanks, low shows zeros
// - Match asserts when counter equals compare
// - Preset loads with scan oscillator free-running
// - Zero asserts whenever counter is zero
// - Preset scans msd to lsd, repeats if held
// - Counter clear leaves compare register intact
module bcdudc_top
  import bcdudc_pkg::*;
#(
  parameter int SLOT_CYC = BCDUDC_SLOT_CYC
) (
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_nrst,
  // Counting controls
  input  wire logic          i_count,
  input  wire logic          i_dir_up,
  input  wire logic          i_cnt_clear_n,
  input  wire logic          i_latch_update_n,
  // Three-level controls
  input  wire bcdudc_tri_s   i_counter_preset_pin,
  input  wire bcdudc_tri_s   i_compare_preset_pin,
  input  wire bcdudc_tri_s   i_display_ctl,
  // BCD port
  input  wire logic [3:0]    i_bcd,
  output logic [3:0]         o_bcd,
  output logic               o_bcd_oe,
  // Display drive
  output logic [3:0]         o_digit_strobe,
  output logic [3:0]         o_seg_val,
  output logic               o_seg_en,
  // Flags
  output logic               o_match,
  output logic               o_zero,
  output logic               o_irq,
  // Register port
  input  wire logic [2:0]    i_addr,
  input  wire logic [15:0]   i_wdata,
  input  wire logic          i_wr,
  input  wire logic          i_rd,
  output logic [15:0]        o_rdata
);

  bcdudc_state_e state_reg;                 // Scan sequencer state
  logic [15:0]   cnt_reg;                   // Four BCD counter digits
  logic [15:0]   cmp_reg;                   // Compare register
  logic [15:0]   latch_reg;                 // Output latches
  logic [1:0]    dig_reg;                   // Current scan digit
  logic [15:0]   slot_reg;                  // Scan slot divider
  logic          count_d_reg;               // Count input, last cycle
  logic          ld_cnt_reg;                // Pass loads the counter
  logic          ld_cmp_reg;                // Pass loads the compare register
  logic [3:0]    status_reg;                // Sticky events
  logic [3:0]    mask_reg;                  // Interrupt mask
  logic          slot_tick;                 // Last cycle of a scan slot
  logic          count_pulse;               // Rising edge of count input
  logic          preset_req;                // Either preset pin high
  logic [15:0]   step_val;                  // Counter after one step
  logic          step_wrap;                 // Step rolled over
  logic [3:0]    ev;                        // Events this cycle
  logic [3:0]    blank;                     // Leading-zero blank per digit
  logic [3:0]    cur_dig;                   // Latched value of scan digit
  logic          rd_status;                 // Status register being read

  // One BCD step up or down, with roll-over flag
  function automatic logic [16:0] bcd_step(input logic [15:0] v, input logic up);
    logic [15:0] r;
    logic        c;
    logic [3:0]  d;
    r = v;
    c = 1'b1;
    for (int i = 0; i < 4; i++) begin
      d = v[i*4 +: 4];
      if (c) begin
        if (up) begin
          r[i*4 +: 4] = (d >= 4'h9) ? 4'h0 : 4'(d + 4'h1);
          c = (d >= 4'h9);
        end else begin
          r[i*4 +: 4] = (d == 4'h0) ? 4'h9 : 4'(d - 4'h1);
          c = (d == 4'h0);
        end
      end
    end
    return {c, r};
  endfunction

  // Combinational helpers
  assign count_pulse = i_count & ~count_d_reg;
  assign preset_req  = i_counter_preset_pin.drv_hi | i_compare_preset_pin.drv_hi;
  assign {step_wrap, step_val} = bcd_step(cnt_reg, i_dir_up);
  assign slot_tick   = (slot_reg == 16'(SLOT_CYC - 1));
  assign cur_dig     = latch_reg[dig_reg*4 +: 4];
  assign rd_status   = i_rd & (i_addr == BCDUDC_ADDR_STATUS);

  // Leading-zero blanking: a digit above the lsd blanks while it and all above are zero
  always_comb begin
    blank[3] = (latch_reg[15:12] == 4'h0) & ~i_display_ctl.drv_lo;
    blank[2] = blank[3] & (latch_reg[11:8] == 4'h0);
    blank[1] = blank[2] & (latch_reg[7:4] == 4'h0);
    blank[0] = 1'b0;
  end

  // Count edge detector
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      count_d_reg <= 1'b0;
    end else begin
      count_d_reg <= i_count;
    end
  end

  // Scan oscillator divider: restarts at preset entry, stopped at once by display off
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      slot_reg <= 16'h0000;
    end else if (state_reg == BCDUDC_ST_OFF || i_compare_preset_pin.drv_lo || slot_tick
                 || (state_reg == BCDUDC_ST_NORMAL && preset_req)) begin
      slot_reg <= 16'h0000;
    end else begin
      slot_reg <= slot_reg + 16'h0001;   // free-running in preset
    end
  end

  // Scan sequencer and preset pass control
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg  <= BCDUDC_ST_NORMAL;
      dig_reg    <= BCDUDC_DIG_MSD;
      ld_cnt_reg <= 1'b0;
      ld_cmp_reg <= 1'b0;
    end else if (i_compare_preset_pin.drv_lo) begin
      state_reg <= BCDUDC_ST_OFF;
      dig_reg   <= BCDUDC_DIG_MSD;
    end else begin
      case (state_reg)
        BCDUDC_ST_NORMAL: begin
          if (preset_req) begin
            state_reg  <= BCDUDC_ST_PRESET;
            dig_reg    <= BCDUDC_DIG_MSD;
            ld_cnt_reg <= i_counter_preset_pin.drv_hi;
            ld_cmp_reg <= i_compare_preset_pin.drv_hi;
          end else if (slot_tick) begin
            dig_reg <= dig_reg - 2'h1;
          end
        end
        BCDUDC_ST_PRESET: begin
          if (slot_tick) begin
            if (dig_reg != BCDUDC_DIG_LSD) begin
              dig_reg <= dig_reg - 2'h1;
            end else begin
              // End of pass: resample and repeat while held
              dig_reg    <= BCDUDC_DIG_MSD;
              ld_cnt_reg <= i_counter_preset_pin.drv_hi;
              ld_cmp_reg <= i_compare_preset_pin.drv_hi;
              if (!preset_req) begin
                state_reg <= BCDUDC_ST_NORMAL;
              end
            end
          end
        end
        BCDUDC_ST_OFF: begin
          state_reg <= BCDUDC_ST_NORMAL;
          dig_reg   <= BCDUDC_DIG_MSD;
        end
        default: begin
          state_reg <= BCDUDC_ST_NORMAL;
        end
      endcase
    end
  end

  // Counter: clear, then preset digit load, then counting
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_reg <= BCDUDC_RST_COUNT;
    end else if (!i_cnt_clear_n) begin
      cnt_reg <= BCDUDC_RST_COUNT;
    end else if (state_reg == BCDUDC_ST_PRESET && slot_tick && ld_cnt_reg) begin
      cnt_reg[dig_reg*4 +: 4] <= i_bcd;
    end else if (count_pulse) begin
      cnt_reg <= step_val;
    end
  end

  // Compare register: only a preset pass changes it
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cmp_reg <= BCDUDC_RST_CMP;
    end else if (state_reg == BCDUDC_ST_PRESET && slot_tick && ld_cmp_reg) begin
      cmp_reg[dig_reg*4 +: 4] <= i_bcd;
    end
  end

  // Output latches follow the counter while store is low
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      latch_reg <= BCDUDC_RST_COUNT;
    end else if (!i_latch_update_n) begin
      latch_reg <= cnt_reg;
    end
  end

  // Match and zero flags
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_match <= 1'b0;
      o_zero  <= 1'b0;
    end else begin
      o_match <= (cnt_reg == cmp_reg);
      o_zero  <= (cnt_reg == 16'h0000);
    end
  end

  // BCD port drive: latched digit in normal scan with both preset pins floating, floated otherwise
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_bcd    <= 4'h0;
      o_bcd_oe <= 1'b0;
    end else begin
      o_bcd    <= cur_dig;
      o_bcd_oe <= (state_reg == BCDUDC_ST_NORMAL) & ~preset_req
                  & ~i_counter_preset_pin.drv_lo
                  & ~i_compare_preset_pin.drv_lo;
    end
  end

  // Digit strobes and segment drive
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_digit_strobe <= 4'h0;
      o_seg_val      <= 4'h0;
      o_seg_en       <= 1'b0;
    end else if (state_reg == BCDUDC_ST_OFF || i_compare_preset_pin.drv_lo) begin
      o_digit_strobe <= 4'h0;
      o_seg_val      <= 4'h0;
      o_seg_en       <= 1'b0;
    end else begin
      o_digit_strobe <= 4'(4'h1 << dig_reg);
      o_seg_val      <= cur_dig;
      o_seg_en       <= ~i_display_ctl.drv_hi & ~blank[dig_reg];
    end
  end

  // Events: rising match, rising zero, preset pass done, roll-over
  assign ev[BCDUDC_EV_MATCH]  = (cnt_reg == cmp_reg) & ~o_match;
  assign ev[BCDUDC_EV_ZERO]   = (cnt_reg == 16'h0000) & ~o_zero;
  assign ev[BCDUDC_EV_PRESET] = (state_reg == BCDUDC_ST_PRESET) & slot_tick
                                & (dig_reg == BCDUDC_DIG_LSD);
  assign ev[BCDUDC_EV_WRAP]   = count_pulse & step_wrap & i_cnt_clear_n
                                & ~(state_reg == BCDUDC_ST_PRESET & slot_tick & ld_cnt_reg);

  // Sticky status, cleared by read; a new event wins over the clear
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      status_reg <= 4'h0;
    end else if (rd_status) begin
      status_reg <= ev;
    end else begin
      status_reg <= status_reg | ev;
    end
  end

  // Mask register write
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mask_reg <= BCDUDC_RST_MASK;
    end else if (i_wr && i_addr == BCDUDC_ADDR_MASK) begin
      mask_reg <= i_wdata[BCDUDC_EV_W-1:0];
    end
  end

  // Interrupt level from the next status value
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_irq <= 1'b0;
    end else if (rd_status) begin
      o_irq <= |(ev & mask_reg);
    end else begin
      o_irq <= |((status_reg | ev) & mask_reg);
    end
  end

  // Read data, one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      case (i_addr)
        BCDUDC_ADDR_STATUS:  o_rdata <= {12'h000, status_reg};
        BCDUDC_ADDR_MASK:    o_rdata <= {12'h000, mask_reg};
        BCDUDC_ADDR_COUNT:   o_rdata <= cnt_reg;
        BCDUDC_ADDR_COMPARE: o_rdata <= cmp_reg;
        BCDUDC_ADDR_LATCH:   o_rdata <= latch_reg;
        default:             o_rdata <= 16'h0000;
      endcase
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_latch_hold: assert property (i_latch_update_n |=> $stable(latch_reg))
    else $error("latch changed while store high");
  a_latch_copy: assert property (!i_latch_update_n |=> latch_reg == $past(cnt_reg))
    else $error("latch did not copy counter");
  a_count_step: assert property (count_pulse && i_cnt_clear_n
      && state_reg == BCDUDC_ST_NORMAL |=> cnt_reg == $past(step_val))
    else $error("counter did not step");
  a_port_float: assert property (i_counter_preset_pin.drv_lo |=> !o_bcd_oe)
    else $error("port driven while counter preset low");
  a_off_dark: assert property (i_compare_preset_pin.drv_lo
      |=> state_reg == BCDUDC_ST_OFF && dig_reg == BCDUDC_DIG_MSD
          && o_digit_strobe == 4'h0 && !o_seg_en && slot_reg == 16'h0000)
    else $error("off state not entered");
  a_seg_off: assert property (i_display_ctl.drv_hi |=> !o_seg_en)
    else $error("segments on while disabled");
  a_match_flag: assert property ($past(i_nrst) |-> o_match == $past(cnt_reg==cmp_reg))
    else $error("match flag wrong");
  a_zero_flag: assert property ($past(i_nrst) |-> o_zero == $past(cnt_reg==16'h0000))
    else $error("zero flag wrong");
  a_clear_cnt: assert property (!i_cnt_clear_n |=> cnt_reg == 16'h0000)
    else $error("counter not cleared");
  a_cmp_keep: assert property (state_reg != BCDUDC_ST_PRESET |=> $stable(cmp_reg))
    else $error("compare changed outside preset");
  a_preset_start: assert property (state_reg == BCDUDC_ST_NORMAL && preset_req
      && !i_compare_preset_pin.drv_lo
      |=> state_reg == BCDUDC_ST_PRESET && dig_reg == BCDUDC_DIG_MSD)
    else $error("preset pass did not start at msd");
  c_preset_pass: cover property (ev[BCDUDC_EV_PRESET]);
  c_match_rise: cover property (ev[BCDUDC_EV_MATCH] ##1 o_match);
  c_irq_high: cover property (o_irq ##1 rd_status);
  c_wrap: cover property (ev[BCDUDC_EV_WRAP]);

endmodule // bcdudc_top

// >>> shared/bcdudc_pkg.sv
package bcdudc_pkg;

  // Register offsets on the plain register port
  localparam logic [2:0] BCDUDC_ADDR_STATUS  = 3'h0;
  localparam logic [2:0] BCDUDC_ADDR_MASK    = 3'h1;
  localparam logic [2:0] BCDUDC_ADDR_COUNT   = 3'h2;
  localparam logic [2:0] BCDUDC_ADDR_COMPARE = 3'h3;
  localparam logic [2:0] BCDUDC_ADDR_LATCH   = 3'h4;

  // Status and mask bit positions
  localparam int BCDUDC_EV_MATCH  = 0;
  localparam int BCDUDC_EV_ZERO   = 1;
  localparam int BCDUDC_EV_PRESET = 2;
  localparam int BCDUDC_EV_WRAP   = 3;
  localparam int BCDUDC_EV_W      = 4;

  // Reset values
  localparam logic [15:0] BCDUDC_RST_COUNT = 16'h0000;
  localparam logic [15:0] BCDUDC_RST_CMP   = 16'h0000;
  localparam logic [3:0]  BCDUDC_RST_MASK  = 4'h0;

  // Digit indices of the scan
  localparam logic [1:0] BCDUDC_DIG_MSD = 2'h3;
  localparam logic [1:0] BCDUDC_DIG_LSD = 2'h0;

  // Scan slot length: time and derived count at 100 MHz
  localparam int BCDUDC_CLK_NS      = 10;
  localparam int BCDUDC_SLOT_NS     = 10000;
  localparam int BCDUDC_SLOT_CYC    = (BCDUDC_SLOT_NS + BCDUDC_CLK_NS - 1) / BCDUDC_CLK_NS;

  // Three-level control pin: neither bit set means floating
  typedef struct packed {
    logic drv_hi;   // Pin driven high
    logic drv_lo;   // Pin driven low
  } bcdudc_tri_s;

  // Scan sequencer states, Gray along normal -> preset -> off
  typedef enum logic [1:0] {
    BCDUDC_ST_NORMAL = 2'b00,
    BCDUDC_ST_PRESET = 2'b01,
    BCDUDC_ST_OFF    = 2'b11
  } bcdudc_state_e;

endpackage

// >>> dv/bcdudc_thumbwheel.sv
`timescale 1ns/1ns
// Thumbwheel switch bank seen through the digit strobes
module bcdudc_thumbwheel (
  // Switch setting and digit strobes
  input  wire logic [15:0] i_value,
  input  wire logic [3:0]  i_strobe,
  // Switch side of the BCD lines
  output logic [3:0]       o_bcd
);
  // Diode-isolated switches; with no strobe the pull-downs give zero
  always_comb begin
    case (i_strobe)
      4'h8:    o_bcd = i_value[15:12];
      4'h4:    o_bcd = i_value[11:8];
      4'h2:    o_bcd = i_value[7:4];
      4'h1:    o_bcd = i_value[3:0];
      default: o_bcd = 4'h0;
    endcase
  end
endmodule // bcdudc_thumbwheel

// >>> dv/bcd_updown_counter_control_tb.sv
`timescale 1ns/1ns
module bcd_updown_counter_control_tb;
  import bcdudc_pkg::*;
  localparam int          SLOT = 4;     // Short scan slot
  localparam bcdudc_tri_s T_FL = 2'h0;  // Pin floating
  localparam bcdudc_tri_s T_HI = 2'h2;  // Pin driven high
  localparam bcdudc_tri_s T_LO = 2'h1;  // Pin driven low
  // Stimulus
  logic        clk = 0, nrst = 0, cnt = 0, up = 1, clr_n = 1, lat_n = 1, wr = 0, rd = 0;
  bcdudc_tri_s cpre = T_FL, rpre = T_FL, dctl = T_FL;
  logic [2:0]  addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  // Observed outputs and BCD lines
  logic [3:0]  bcd_o, strobe, seg_val, sw_bcd, bcd_w;
  logic        oe, seg_en, match, zero, irq;
  logic [15:0] rdata;
  // Bench state
  logic [15:0] model = 16'h0000, sw_val = 16'h0000, got;
  int          n_errors = 0, tests_run = 0, cyc = 0, lit;
  logic        casc_q = 1'b0;  // Cascade partner flop

  // Free-running clock
  always #5 clk = ~clk;
  // Line level: device drives when enabled, switches otherwise
  assign bcd_w = oe ? bcd_o : sw_bcd;

  bcdudc_top #(.SLOT_CYC(SLOT)) uut (
    .i_clk(clk), .i_nrst(nrst), .i_count(cnt), .i_dir_up(up), .i_cnt_clear_n(clr_n),
    .i_latch_update_n(lat_n), .i_counter_preset_pin(cpre), .i_compare_preset_pin(rpre),
    .i_display_ctl(dctl), .i_bcd(bcd_w), .o_bcd(bcd_o), .o_bcd_oe(oe),
    .o_digit_strobe(strobe), .o_seg_val(seg_val), .o_seg_en(seg_en), .o_match(match),
    .o_zero(zero), .o_irq(irq), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata));
  bcdudc_thumbwheel sw (.i_value(sw_val), .i_strobe(strobe), .o_bcd(sw_bcd));

  // Decimal to packed BCD and back
  function automatic logic [15:0] to_bcd(int n);
    return {4'(n / 1000), 4'((n / 100) % 10), 4'((n / 10) % 10), 4'(n % 10)};
  endfunction
  function automatic int to_int(logic [15:0] v);
    return v[15:12] * 1000 + v[11:8] * 100 + v[7:4] * 10 + v[3:0];
  endfunction

  // Verdict and end of run
  task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Comparisons
  task automatic chk(logic [15:0] g, logic [15:0] e, string m);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk1(logic g, logic e, string m);
    chk({15'h0000, g}, {15'h0000, e}, m);
  endtask
  // Wait n edges, then let updates land
  task automatic settle(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Register port cycles
  task automatic wr_reg(logic [2:0] a, logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk) rd <= 1'b0;
    #1 d = rdata;
  endtask
  // One count pulse, model follows unless clear is low
  task automatic pulse(bit dir);
    @(posedge clk);
    up <= dir;
    cnt <= 1'b1;
    @(posedge clk) cnt <= 1'b0;
    @(posedge clk);
    model = to_bcd(dir ? (to_int(model) + 1) % 10000 : (to_int(model) + 9999) % 10000);
    if (clr_n == 1'b0) model = 16'h0000;
  endtask
  // Drive a preset pin high for a while, then float it
  task automatic preset(bit to_cmp, int hold);
    @(posedge clk);
    if (to_cmp) rpre <= T_HI;
    else cpre <= T_HI;
    settle(hold);
    chk1(oe, 1'b0, "port driven in preset");
    @(posedge clk);
    rpre <= T_FL;
    cpre <= T_FL;
    settle(4 * SLOT + 8);
  endtask
  // Count lit cycles over two scan passes
  task automatic scan_lit;
    settle(3);
    lit = 0;
    repeat (8 * SLOT) begin
      settle(1);
      if (seg_en === 1'b1) lit++;
    end
  endtask

  // Cascade partner: flop clocked on the lowest digit strobe keeps an unblanked digit
  always @(negedge clk) begin
    if (strobe === 4'h1) casc_q <= seg_en;
  end

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      $display("FAIL %0t timeout", $time);
      end_of_test;
    end
  end

  // Main sequence
  initial begin
    void'($urandom(32'ha577_8aad));
    settle(5);
    @(posedge clk) nrst <= 1'b1;
    settle(2);
    chk1(zero, 1'b1, "zero after reset");
    chk1(match, 1'b1, "match after reset");
    rd_reg(3'h7, got);
    chk(got, 16'h0000, "unmapped read");
    // Down wrap corner, then random counting
    pulse(1'b0);
    rd_reg(BCDUDC_ADDR_COUNT, got);
    chk(got, 16'h9999, "down wrap");
    repeat (40) begin
      pulse(1'($urandom % 2));
      rd_reg(BCDUDC_ADDR_COUNT, got);
      chk(got, model, "count");
      chk1(zero, model == 16'h0000, "zero flag");
    end
    // Store low copies, high holds
    @(posedge clk) lat_n <= 1'b0;
    rd_reg(BCDUDC_ADDR_LATCH, got);
    rd_reg(BCDUDC_ADDR_LATCH, got);
    chk(got, model, "latch follows");
    sw_val = model;
    @(posedge clk) lat_n <= 1'b1;
    pulse(1'b1);
    rd_reg(BCDUDC_ADDR_LATCH, got);
    chk(got, sw_val, "latch holds");
    // Compare preset with unmasked pass-done interrupt
    wr_reg(BCDUDC_ADDR_MASK, 16'h0004);
    rd_reg(BCDUDC_ADDR_MASK, got);
    chk(got, 16'h0004, "mask readback");
    rd_reg(BCDUDC_ADDR_STATUS, got);
    sw_val = to_bcd($urandom % 10000);
    preset(1'b1, 3);
    rd_reg(BCDUDC_ADDR_COMPARE, got);
    chk(got, sw_val, "compare loaded");
    chk1(irq, 1'b1, "irq raised");
    rd_reg(BCDUDC_ADDR_STATUS, got);
    chk(got & 16'h0004, 16'h0004, "status pass done");
    settle(2);
    chk1(irq, 1'b0, "irq cleared by read");
    // Counter preset held over several passes, interrupt masked
    wr_reg(BCDUDC_ADDR_MASK, 16'h0000);
    preset(1'b0, 40);
    chk1(irq, 1'b0, "irq masked");
    rd_reg(BCDUDC_ADDR_COUNT, got);
    chk(got, sw_val, "counter loaded");
    chk1(match, 1'b1, "match on equal");
    model = sw_val;
    pulse(1'b1);
    settle(1);
    chk1(match, 1'b0, "match drops");
    // Clear forces zero and keeps compare
    @(posedge clk) clr_n <= 1'b0;
    pulse(1'b1);
    rd_reg(BCDUDC_ADDR_COUNT, got);
    chk(got, 16'h0000, "clear");
    chk1(zero, 1'b1, "zero on clear");
    rd_reg(BCDUDC_ADDR_COMPARE, got);
    chk(got, sw_val, "compare kept");
    @(posedge clk) clr_n <= 1'b1;
    // Port off leaves counting alone
    @(posedge clk) cpre <= T_LO;
    settle(3);
    chk1(oe, 1'b0, "port off");
    pulse(1'b1);
    rd_reg(BCDUDC_ADDR_COUNT, got);
    chk(got, model, "count in port off");
    @(posedge clk) cpre <= T_FL;
    settle(3);
    chk1(oe, 1'b1, "port back on");
    // Display off stops the scan, counting goes on
    @(posedge clk) rpre <= T_LO;
    settle(3);
    chk({12'h000, strobe}, 16'h0000, "strobes off");
    chk1(seg_en, 1'b0, "segments off");
    chk1(oe, 1'b0, "port off in display off");
    pulse(1'b0);
    rd_reg(BCDUDC_ADDR_COUNT, got);
    chk(got, model, "count in display off");
    @(posedge clk) rpre <= T_FL;
    settle(2);
    chk({12'h000, strobe}, 16'h0008, "scan restarts at msd");
    // Display control on a value with leading zeros, latches following the counter
    sw_val = 16'h0005;
    preset(1'b0, 3);
    @(posedge clk) lat_n <= 1'b0;
    scan_lit;
    chk(16'(lit), 16'(2 * SLOT), "leading zeros blanked");
    chk1(casc_q, 1'b1, "cascade flop set");
    while (strobe !== 4'h1) settle(1);
    chk({12'h000, seg_val}, 16'h0005, "lsd segment value");
    chk({12'h000, bcd_o}, 16'h0005, "lsd port value");
    @(posedge clk) dctl <= T_LO;
    scan_lit;
    chk(16'(lit), 16'(8 * SLOT), "blanking inhibited");
    @(posedge clk) dctl <= T_HI;
    scan_lit;
    chk(16'(lit), 16'h0000, "segments disabled");
    chk1(casc_q, 1'b0, "cascade flop clear");
    end_of_test;
  end
endmodule // bcd_updown_counter_control_tb
